// ==== rtl/sqm_datapath.sv ====
/*
 * Square, square-accumulate and square-subtract datapath with its own
 * accumulator file, temporary register three and AHB-Lite register slave.
 * Assumes instruction and memory operand arrive on the core clock from the
 * decoder and operand fetch; one instruction may be offered every cycle.
 */
`timescale 1ns/1ps
module sqm_datapath
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        instr_valid,
	input  wire logic [23:0] instr_word,
	input  wire logic [15:0] mem_operand,
	output logic             result_valid,
	output logic      [1:0]  result_dest,
	output logic      [39:0] result_acc,
	output logic      [15:0] temporary_register_three,
	output logic      [3:0]  dest_acc_overflow_flag,
	output logic             irq
);

	logic [sqm_pkg::ACC_W-1:0] acc_ff [sqm_pkg::ACC_N];
	logic [sqm_pkg::MODE_W-1:0] mode_ff;
	logic [3:0]                 ovf_ff;
	logic [sqm_pkg::EV_W-1:0]   irq_st_ff;
	logic [sqm_pkg::EV_W-1:0]   irq_msk_ff;
	logic [15:0]                tmp3_ff;
	logic                       res_vld_ff;
	logic [1:0]                 res_dst_ff;
	logic [39:0]                res_acc_ff;
	logic                       fractional_mode;
	logic                       multiply_saturate_mode;
	logic                       wide_computation_mode;
	logic                       rounding_method_select;
	logic                       dunit_saturate_enable;
	assign fractional_mode        = mode_ff[sqm_pkg::MODE_FRACT];
	assign multiply_saturate_mode = mode_ff[sqm_pkg::MODE_MSAT];
	assign wide_computation_mode  = mode_ff[sqm_pkg::MODE_WIDE];
	assign rounding_method_select = mode_ff[sqm_pkg::MODE_RNDSEL];
	assign dunit_saturate_enable  = mode_ff[sqm_pkg::MODE_DSAT];

	// Decode
	sqm_pkg::sqm_op_t dec_op;
	logic             dec_mem;
	logic             dec_rnd;
	logic             dec_t3;
	logic [1:0]       dec_dst;
	logic [1:0]       dec_src;
	logic             dec_bad;
	always_comb
	begin
		dec_op  = sqm_pkg::SQM_OP_NONE;
		dec_mem = 1'b0;
		dec_rnd = 1'b0;
		dec_t3  = 1'b0;
		dec_dst = 2'h0;
		dec_src = 2'h0;
		if (instr_word[23:17] == sqm_pkg::OPC_REG_HI)
		begin
			dec_dst = instr_word[15:14];
			dec_src = instr_word[13:12];
			dec_rnd = instr_word[8];
			if (instr_word[11:9] == sqm_pkg::SUB_SQR_REG)
				dec_op = sqm_pkg::SQM_OP_SQR;
			else if (instr_word[11:9] == sqm_pkg::SUB_SQA_REG)
				dec_op = sqm_pkg::SQM_OP_SQA;
			else if (instr_word[11:9] == sqm_pkg::SUB_SQS_REG)
				dec_op = sqm_pkg::SQM_OP_SQS;
		end
		else if (instr_word[23:16] == sqm_pkg::OPC_SQX_MEM)
		begin
			dec_mem = 1'b1;
			dec_t3  = instr_word[7];
			dec_rnd = instr_word[6];
			dec_dst = instr_word[5:4];
			dec_src = instr_word[1:0];
			if (instr_word[3:2] == sqm_pkg::SUB_SQA_MEM)
				dec_op = sqm_pkg::SQM_OP_SQA;
			else if (instr_word[3:2] == sqm_pkg::SUB_SQS_MEM)
				dec_op = sqm_pkg::SQM_OP_SQS;
		end
		else if (instr_word[23:16] == sqm_pkg::OPC_SQR_MEM
			&& instr_word[3:2] == sqm_pkg::SUB_SQR_MEM)
		begin
			dec_mem = 1'b1;
			dec_t3  = instr_word[7];
			dec_rnd = instr_word[6];
			dec_dst = instr_word[5:4];
			dec_op  = sqm_pkg::SQM_OP_SQR;
		end
	end

	assign dec_bad = instr_valid && (dec_op == sqm_pkg::SQM_OP_NONE);

	// Multiply
	logic signed [16:0] opd;
	logic signed [33:0] prod;
	logic        [33:0] prod_sh;
	logic               mul_ovf;
	logic        [31:0] prod32;
	logic        [39:0] prod40;
	always_comb
	begin
		if (dec_mem)
			opd = {mem_operand[15], mem_operand};
		else
			opd = acc_ff[dec_src][32:16];
	end

	assign prod    = opd * opd;
	assign prod_sh = fractional_mode ? {prod[32:0], 1'b0} : prod;
	assign mul_ovf = !((&prod_sh[33:31]) || !(|prod_sh[33:31]));
	// Without multiply saturation the product simply wraps in 32 bits
	assign prod32  = (mul_ovf && multiply_saturate_mode) ? 32'h7fffffff
		: prod_sh[31:0];
	assign prod40  = {{8{prod32[31]}}, prod32};

	// Accumulate, round
	logic [39:0] base;
	logic [40:0] sum41;
	logic [41:0] sum42;
	logic [41:0] rnd42;
	logic [41:0] pre_sat;
	always_comb
	begin
		unique case (dec_op)
			sqm_pkg::SQM_OP_SQA:
				base = dec_mem ? acc_ff[dec_src] : acc_ff[dec_dst];
			sqm_pkg::SQM_OP_SQS:
				base = dec_mem ? acc_ff[dec_src] : acc_ff[dec_dst];
			default:
				base = 40'h0000000000;
		endcase
	end

	always_comb
	begin
		if (dec_op == sqm_pkg::SQM_OP_SQS)
			sum41 = {base[39], base} - {prod40[39], prod40};
		else
			sum41 = {base[39], base} + {prod40[39], prod40};
	end

	assign sum42 = {sum41[40], sum41};
	assign rnd42 = sum42 + {26'h0, sqm_pkg::RND_HALF};

	always_comb
	begin
		pre_sat = sum42;
		if (dec_rnd)
		begin
			pre_sat = {rnd42[41:16], 16'h0000};
			// Nearest mode breaks exact ties toward an even upper half
			if (rounding_method_select && sum42[15:0] == sqm_pkg::RND_HALF)
				pre_sat[16] = 1'b0;
		end
	end

	logic [39:0] sat_res;
	logic        res_ovf;
	// Legacy mode needs no separate path: results already match while
	// wide mode is off, and overflow follows the same rule
	sqm_sat_unit u_sat
	(
		.sum_in                (pre_sat),
		.wide_computation_mode (wide_computation_mode),
		.dunit_saturate_enable (dunit_saturate_enable),
		.result                (sat_res),
		.overflow              (res_ovf)
	);

	logic exec;
	assign exec = instr_valid && !dec_bad;

	// AHB-Lite slave
	logic       ap_take;
	logic       wr_pend_ff;
	logic       rd_pend_ff;
	logic [7:0] addr_ff;
	logic [31:0] rdata_ff;
	logic [31:0] rd_mux;
	logic       sw_wr;
	logic       st_read;
	logic       acc_hit;
	logic [1:0] acc_idx;
	logic       acc_hi;
	assign ap_take = hsel && hready && htrans[1];
	assign sw_wr   = wr_pend_ff;
	assign acc_hit = addr_ff >= sqm_pkg::OFS_ACC_LO && addr_ff < sqm_pkg::OFS_ACC_END;
	assign acc_idx = addr_ff[4:3];
	assign acc_hi  = addr_ff[2];
	assign st_read = rd_pend_ff && addr_ff == sqm_pkg::OFS_IRQ_ST;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
		end
		else
		begin
			wr_pend_ff <= ap_take && hwrite;
			rd_pend_ff <= ap_take && !hwrite;
			if (ap_take)
				addr_ff <= {haddr[7:2], 2'h0};
		end
	end

	always_comb
	begin
		rd_mux = 32'h00000000;
		if (acc_hit)
			rd_mux = acc_hi ? {24'h000000, acc_ff[acc_idx][39:32]} : acc_ff[acc_idx][31:0];
		else
		begin
			unique case (addr_ff)
				sqm_pkg::OFS_MODE:    rd_mux = {26'h0, mode_ff};
				sqm_pkg::OFS_OVF:     rd_mux = {28'h0, ovf_ff};
				sqm_pkg::OFS_IRQ_ST:  rd_mux = {29'h0, irq_st_ff};
				sqm_pkg::OFS_IRQ_MSK: rd_mux = {29'h0, irq_msk_ff};
				sqm_pkg::OFS_TMP3:    rd_mux = {16'h0000, tmp3_ff};
				default:              rd_mux = 32'h00000000;
			endcase
		end
	end

	// Reads take one wait state so that a preceding write is visible
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata_ff <= 32'h00000000;
		else if (rd_pend_ff)
			rdata_ff <= rd_mux;
	end

	assign hrdata    = rdata_ff;
	assign hreadyout = !rd_pend_ff;
	assign hresp     = 1'b0;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_ff    <= sqm_pkg::MODE_RESET;
			irq_msk_ff <= 3'h0;
		end
		else if (sw_wr && addr_ff == sqm_pkg::OFS_MODE)
			mode_ff <= hwdata[sqm_pkg::MODE_W-1:0];
		else if (sw_wr && addr_ff == sqm_pkg::OFS_IRQ_MSK)
			irq_msk_ff <= hwdata[sqm_pkg::EV_W-1:0];
	end

	// Accumulator file; datapath write wins over a software write
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < sqm_pkg::ACC_N; i++)
				acc_ff[i] <= 40'h0000000000;
		end
		else
		begin
			if (sw_wr && acc_hit)
			begin
				if (acc_hi)
					acc_ff[acc_idx][39:32] <= hwdata[7:0];
				else
					acc_ff[acc_idx][31:0] <= hwdata;
			end
			if (exec)
				acc_ff[dec_dst] <= sat_res;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			tmp3_ff <= 16'h0000;
		else if (exec && dec_mem && dec_t3)
			tmp3_ff <= mem_operand;
	end

	// Overflow flags: hardware set wins over write-one-to-clear
	logic [3:0] ovf_set;
	assign ovf_set = (exec && res_ovf) ? (4'h1 << dec_dst) : 4'h0;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			ovf_ff <= 4'h0;
		else if (sw_wr && addr_ff == sqm_pkg::OFS_OVF)
			ovf_ff <= (ovf_ff & ~hwdata[3:0]) | ovf_set;
		else
			ovf_ff <= ovf_ff | ovf_set;
	end

	logic [sqm_pkg::EV_W-1:0] ev;
	assign ev = {dec_bad, exec && mul_ovf, exec && res_ovf};

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_st_ff <= 3'h0;
		else if (st_read)
			irq_st_ff <= ev;
		else
			irq_st_ff <= irq_st_ff | ev;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			res_vld_ff <= 1'b0;
			res_dst_ff <= 2'h0;
			res_acc_ff <= 40'h0000000000;
		end
		else
		begin
			res_vld_ff <= exec;
			if (exec)
			begin
				res_dst_ff <= dec_dst;
				res_acc_ff <= sat_res;
			end
		end
	end

	assign result_valid             = res_vld_ff;
	assign result_dest              = res_dst_ff;
	assign result_acc               = res_acc_ff;
	assign temporary_register_three = tmp3_ff;
	assign dest_acc_overflow_flag   = ovf_ff;
	assign irq                      = |(irq_st_ff & irq_msk_ff);

endmodule

// ==== rtl/sqm_pkg.sv ====
/*
 * Constants for the square multiply-accumulate datapath: opcode patterns,
 * register offsets, field positions and reset values.
 * Assumes a single core clock domain and a 32-bit AHB-Lite register bus.
 */
package sqm_pkg;

	localparam int ACC_W = 40;
	localparam int OPD_W = 17;
	localparam int MEM_W = 16;
	localparam int ACC_N = 4;

	// Register byte offsets
	localparam logic [7:0] OFS_MODE    = 8'h00;
	localparam logic [7:0] OFS_OVF     = 8'h04;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h0c;
	localparam logic [7:0] OFS_TMP3    = 8'h10;
	localparam logic [7:0] OFS_ACC_LO  = 8'h20;
	localparam logic [7:0] OFS_ACC_END = 8'h40;

	// Mode register bit positions
	localparam int MODE_FRACT  = 0;
	localparam int MODE_MSAT   = 1;
	localparam int MODE_WIDE   = 2;
	localparam int MODE_RNDSEL = 3;
	localparam int MODE_DSAT   = 4;
	localparam int MODE_LEGACY = 5;
	localparam int MODE_W      = 6;
	localparam logic [5:0] MODE_RESET = 6'h20;

	// Interrupt event bit positions
	localparam int EV_RES_OVF = 0;
	localparam int EV_MUL_OVF = 1;
	localparam int EV_ILLEGAL = 2;
	localparam int EV_W       = 3;

	// Opcode patterns, instruction left aligned in 24 bits
	localparam logic [6:0] OPC_REG_HI  = 7'h2a;
	localparam logic [2:0] SUB_SQR_REG = 3'h4;
	localparam logic [2:0] SUB_SQS_REG = 3'h2;
	localparam logic [2:0] SUB_SQA_REG = 3'h3;
	localparam logic [7:0] OPC_SQR_MEM = 8'hd3;
	localparam logic [7:0] OPC_SQX_MEM = 8'hd2;
	localparam logic [1:0] SUB_SQA_MEM = 2'h2;
	localparam logic [1:0] SUB_SQS_MEM = 2'h3;
	localparam logic [1:0] SUB_SQR_MEM = 2'h2;

	localparam logic [15:0] RND_HALF   = 16'h8000;

	typedef enum logic [1:0] {
		SQM_OP_NONE,
		SQM_OP_SQR,
		SQM_OP_SQA,
		SQM_OP_SQS
	} sqm_op_t;

endpackage

// ==== rtl/sqm_sat_unit.sv ====
/*
 * Result overflow detection and saturation for the accumulator write.
 * Assumes a 42-bit signed input that already holds sum and rounding.
 */
`timescale 1ns/1ps
module sqm_sat_unit
(
	input  wire logic [41:0] sum_in,
	input  wire logic        wide_computation_mode,
	input  wire logic        dunit_saturate_enable,
	output logic      [39:0] result,
	output logic             overflow
);

	logic ovf_wide;
	logic ovf_narrow;

	assign ovf_wide   = !((&sum_in[41:39]) || !(|sum_in[41:39]));
	assign ovf_narrow = !((&sum_in[41:31]) || !(|sum_in[41:31]));
	assign overflow   = wide_computation_mode ? ovf_wide : ovf_narrow;

	always_comb
	begin
		result = sum_in[39:0];
		if (overflow && dunit_saturate_enable)
		begin
			if (wide_computation_mode)
				result = sum_in[41] ? 40'h8000000000 : 40'h7fffffffff;
			else
				result = sum_in[41] ? 40'hff80000000 : 40'h007fffffff;
		end
	end

endmodule

// ==== testbench/sqm_datapath_assertions.sv ====
/*
 * Port checker for sqm_datapath: instruction timing, destinations, temp copy.
 * Assumes one core clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module sqm_datapath_chk
(
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic        instr_valid,
	input wire logic [23:0] instr_word,
	input wire logic [15:0] mem_operand,
	input wire logic        result_valid,
	input wire logic [1:0]  result_dest,
	input wire logic [15:0] temporary_register_three,
	input wire logic [3:0]  dest_acc_overflow_flag
);
	logic       reg_form;
	logic       mem_form;
	logic       known;
	logic       store;
	logic [1:0] dst_reg;
	logic [1:0] dst_mem;
	assign reg_form = instr_word[23:17] == 7'h2a && instr_word[11:9] inside {3'h2, 3'h3, 3'h4};
	assign mem_form = (instr_word[23:16] == 8'hd2 && instr_word[3])
		|| (instr_word[23:16] == 8'hd3 && instr_word[3:2] == 2'h2);
	assign known = reg_form || mem_form;
	assign store = instr_valid && mem_form && instr_word[7];
	assign dst_reg = instr_word[15:14];
	assign dst_mem = instr_word[5:4];
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	property p_exec;
		instr_valid && known |=> result_valid;
	endproperty
	a_exec: assert property (p_exec) else $error("no result");
	property p_refuse;
		!(instr_valid && known) |=> !result_valid;
	endproperty
	a_refuse: assert property (p_refuse) else $error("stray result");
	property p_repeat;
		(instr_valid && known)[*2] |-> result_valid ##1 result_valid;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat lost");
	property p_dst_reg;
		instr_valid && reg_form |=> result_dest == $past(dst_reg);
	endproperty
	a_dst_reg: assert property (p_dst_reg) else $error("reg dest");
	property p_dst_mem;
		instr_valid && mem_form |=> result_dest == $past(dst_mem);
	endproperty
	a_dst_mem: assert property (p_dst_mem) else $error("mem dest");
	property p_tmp_copy;
		store |=> temporary_register_three == $past(mem_operand);
	endproperty
	a_tmp_copy: assert property (p_tmp_copy) else $error("temp copy");
	property p_tmp_hold;
		!store |=> $stable(temporary_register_three);
	endproperty
	a_tmp_hold: assert property (p_tmp_hold) else $error("temp changed");
	property p_flag;
		(dest_acc_overflow_flag & ~$past(dest_acc_overflow_flag)) != 4'h0 |-> $past(instr_valid);
	endproperty
	a_flag: assert property (p_flag) else $error("flag without op");
endmodule

bind sqm_datapath sqm_datapath_chk sqm_datapath_chk_inst (.sys_clk, .rst_b, .instr_valid,
	.instr_word, .mem_operand, .result_valid, .result_dest, .temporary_register_three,
	.dest_acc_overflow_flag);

// ==== testbench/sqm_fetch_model.sv ====
/*
 * Stand-in for decoder and operand fetch: presents one instruction a cycle.
 * Assumes requests change just after a rising edge.
 */
`timescale 1ns/1ps
module sqm_fetch_model
(
	input  wire logic        issue,
	input  wire logic [23:0] word,
	input  wire logic [15:0] opd,
	output logic             instr_valid,
	output logic      [23:0] instr_word,
	output logic      [15:0] mem_operand
);
	// Idle lines show inverted data so nothing leans on a stale operand
	assign instr_valid = issue;
	assign instr_word  = issue ? word : ~word;
	assign mem_operand = issue ? opd : ~opd;
endmodule

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for sqm_datapath: instruction table, then modes,
 * overflow, interrupt and reset tests. Assumes a 40 MHz core clock.
 */
`timescale 1ns/1ps
module tb;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        issue = 1'b0;
	logic [23:0] word = 24'h0;
	logic [15:0] opd = 16'h0;
	logic        instr_valid;
	logic [23:0] instr_word;
	logic [15:0] mem_operand;
	logic        result_valid;
	logic [1:0]  result_dest;
	logic [39:0] result_acc;
	logic [15:0] tmp3;
	logic [3:0]  ovf;
	logic        irq;
	logic [31:0] rd;
	int          bad_count = 0;
	int          n_compared = 0;
	// Rows: instruction, operand, destination, result; later rows use earlier results
	logic [81:0] rows [7] = '{
		{24'hd30088, 16'h0003, 2'h0, 40'h9},
		{24'hd30058, 16'h00c0, 2'h1, 40'h10000},
		{24'hd20028, 16'h0002, 2'h2, 40'hd},
		{24'hd2003e, 16'h0004, 2'h3, 40'hfffffffffd},
		{24'h543800, 16'h0000, 2'h0, 40'h1},
		{24'h543600, 16'h0000, 2'h0, 40'h2},
		{24'h547400, 16'h0000, 2'h1, 40'hffff}};

	sqm_datapath sqm_datapath_inst (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.instr_valid, .instr_word, .mem_operand, .result_valid, .result_dest, .result_acc,
		.temporary_register_three(tmp3), .dest_acc_overflow_flag(ovf), .irq);
	sqm_fetch_model sqm_fetch_model_inst (.issue, .word, .opd, .instr_valid, .instr_word,
		.mem_operand);

	always #12.5 sys_clk = ~sys_clk;

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge sys_clk iff hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk iff hreadyout);
		rd = hrdata;
		#1;
	endtask

	task automatic ex(input logic [23:0] w, input logic [15:0] o);
		@(posedge sys_clk);
		issue <= 1'b1;
		word <= w;
		opd <= o;
		@(posedge sys_clk);
		issue <= 1'b0;
		#1;
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Whole run is about a hundred cycles; this 4000-cycle span leaves ample margin
	initial
	begin
		#100000;
		bad_count++;
		finish_test();
	end

	initial
	begin
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int i = 0; i <= 7; i++)
		begin
			@(posedge sys_clk);
			issue <= i < 7;
			{word, opd} <= rows[i % 7][81:42];
			#1;
			if (i > 0)
			begin
				chk(40'(result_valid), 40'h1);
				chk(40'(result_dest), 40'(rows[i - 1][41:40]));
				chk(result_acc, rows[i - 1][39:0]);
			end
		end
		chk(40'(tmp3), 40'h3);
		$display("table done");
		bus(1'b1, 8'h00, 32'h10);
		ex(24'hd30028, 16'h8000);
		chk(result_acc, 40'h40000000);
		ex(24'hd2002a, 16'h8000);
		chk(result_acc, 40'h007fffffff);
		chk(40'(ovf), 40'h4);
		bus(1'b1, 8'h00, 32'h14);
		ex(24'hd2002a, 16'h8000);
		chk(result_acc, 40'h00bfffffff);
		bus(1'b1, 8'h00, 32'h01);
		ex(24'hd30038, 16'h0003);
		chk(result_acc, 40'h12);
		bus(1'b1, 8'h00, 32'h03);
		ex(24'hd30038, 16'h8000);
		chk(result_acc, 40'h007fffffff);
		bus(1'b1, 8'h00, 32'h08);
		ex(24'hd30078, 16'h00c0);
		chk(result_acc, 40'h10000);
		// Fractional 0x80 squared sits exactly on the half: nearest keeps it even
		bus(1'b1, 8'h00, 32'h09);
		ex(24'hd30078, 16'h0080);
		chk(result_acc, 40'h0);
		bus(1'b1, 8'h00, 32'h30);
		ex(24'hd30038, 16'h0003);
		chk(result_acc, 40'h9);
		ex(24'hd2002a, 16'h8000);
		chk(result_acc, 40'h007fffffff);
		// Negative operand other than 0x8000, so a lost sign extension shows
		ex(24'hd30038, 16'hfffd);
		chk(result_acc, 40'h9);
		ex(24'hffffff, 16'h0000);
		chk(40'(result_valid), 40'h0);
		$display("modes done");
		bus(1'b1, 8'h0c, 32'h0);
		chk(40'(irq), 40'h0);
		bus(1'b1, 8'h0c, 32'h7);
		chk(40'(irq), 40'h1);
		bus(1'b0, 8'h08, 32'h0);
		chk(40'(rd), 40'h7);
		chk(40'(irq), 40'h0);
		bus(1'b0, 8'h04, 32'h0);
		chk(40'(rd), 40'h4);
		bus(1'b1, 8'h04, 32'h4);
		chk(40'(ovf), 40'h0);
		bus(1'b0, 8'h80, 32'h0);
		chk(40'(rd), 40'h0);
		chk(40'(hresp), 40'h0);
		$display("irq done");
		@(posedge sys_clk);
		rst_b <= 1'b0;
		#1;
		chk(40'(tmp3), 40'h0);
		chk(40'(hreadyout), 40'h1);
		$display("reset done");
		finish_test();
	end
endmodule
